// ===== test/pti_host.sv
`timescale 1ns/10ps
module pti_host (
  input  wire logic [7:0] reg_rdata,
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // one byte per strobe; idle bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  // threshold first, then enables, so no event fires on a half-loaded limit
  task automatic arm(input logic [15:0] thr, input logic [7:0] cfg);
    wr(8'h0c, thr[7:0]);
    wr(8'h0d, thr[15:8]);
    wr(8'h0b, cfg);
  endtask
endmodule

// ===== test/pti_threshold_irq_checker.sv
`timescale 1ns/10ps
module pti_chk #(
  parameter int THS_SHIFT = 8
) (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_wr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic                conv_done,
  input wire pti_pkg::pti_press_t conv_pressure,
  input wire pti_pkg::pti_press_t output_pressure,
  input wire logic                irq_out
);
  import pti_pkg::*;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  // output pressure moves only as a result of a conversion
  property p_out_upd; $changed(output_pressure) |-> $past(conv_done); endproperty
  a_out_upd: assert property (p_out_upd) else $error("output moved without conversion");
  property p_irq_rise; $rose(irq_out) |-> $past(conv_done, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose off conversion");
  // a latched request may only drop after a source read or cfg write
  property p_irq_fall;
    $fell(irq_out) |-> $past(conv_done, 2) || $past(reg_rd, 2) || $past(reg_rd, 3) ||
                       $past(reg_wr, 2) || $past(reg_wr, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
  property p_unmapped; reg_rd && reg_addr > 8'h2a |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_w1_zero; reg_rd && reg_addr == 8'h0b |=> !reg_rdata[4] && !reg_rdata[6]; endproperty
  a_w1_zero: assert property (p_w1_zero) else $error("reset bits read back set");
  property p_ths_rw;
    reg_wr && reg_addr == 8'h0c ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h0c |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_ths_rw: assert property (p_ths_rw) else $error("threshold byte lost");
  property p_out_lo; reg_rd && reg_addr == 8'h28 |=> reg_rdata == 8'($past(output_pressure)); endproperty
  a_out_lo: assert property (p_out_lo) else $error("output low byte mismatch");
  property p_out_hi; reg_rd && reg_addr == 8'h2a |=> reg_rdata == 8'($past(output_pressure) >> 16); endproperty
  a_out_hi: assert property (p_out_hi) else $error("output high byte mismatch");
endmodule
bind pti_threshold_irq pti_chk #(.THS_SHIFT(THS_SHIFT)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_done(conv_done), .conv_pressure(conv_pressure), .output_pressure(output_pressure), .irq_out(irq_out));

// ===== test/pti_threshold_irq_tb.sv
`timescale 1ns/10ps
module pti_threshold_irq_tb;
  import pti_pkg::*;
  logic       clk_sys, rst_n, conv_done, irq_out, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
  pti_press_t conv_pressure, output_pressure;
  int         miscompares, check_count, cycles;
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  pti_threshold_irq dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .conv_pressure(conv_pressure), .output_pressure(output_pressure), .irq_out(irq_out));
  pti_host u_host (.reg_rdata(reg_rdata), .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, b);
    chk({16'h0000, b}, {16'h0000, exp});
  endtask
  // conversion pulse, then two cycles so irq has settled
  task automatic cv(input pti_press_t p);
    @(negedge clk_sys);
    conv_done = 1'b1;
    conv_pressure = p;
    @(negedge clk_sys);
    conv_done = 1'b0;
    conv_pressure = ~p;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic ev(input logic [7:0] cfg, input pti_press_t p, input logic exp);
    u_host.wr(8'h0b, cfg);
    cv(p);
    chk({23'h00_0000, irq_out}, {23'h00_0000, exp});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(8'h0b, 8'h00);
    rdchk(8'h0c, 8'h00);
    rdchk(8'h40, 8'h00);
    u_host.wr(8'h0c, 8'h34);
    rdchk(8'h0c, 8'h34);
    u_host.wr(8'h0d, 8'h12);
    rdchk(8'h0d, 8'h12);
    $display("t_reset done");
  endtask
  // limit 0x0010 is 0x1000 at pressure scale; equal to limit is no event
  task automatic t_events;
    u_host.arm(16'h0010, 8'h0b);
    ev(8'h0b, 24'h00_1001, 1'b1);
    rdchk(8'h25, 8'h05);
    ev(8'h0b, 24'h00_1000, 1'b0);
    ev(8'h0b, 24'hff_efff, 1'b1);
    rdchk(8'h25, 8'h06);
    ev(8'h0b, 24'hff_f000, 1'b0);
    ev(8'h09, 24'hff_efff, 1'b0);
    ev(8'h0a, 24'h00_1001, 1'b0);
    ev(8'h03, 24'h00_1001, 1'b0);
    ev(8'h0d, 24'h00_1001, 1'b1);
    ev(8'h0d, 24'h00_0000, 1'b1);
    rdchk(8'h25, 8'h05);
    repeat (3) @(negedge clk_sys);
    chk({23'h00_0000, irq_out}, 24'h00_0000);
    // a low event on the same edge as a source read must survive the read
    u_host.wr(8'h0b, 8'h0f);
    fork
      u_host.rd(8'h25, b);
      cv(24'hff_efff);
    join
    chk({16'h0000, b}, 24'h00_0000);
    chk({23'h00_0000, irq_out}, 24'h00_0001);
    rdchk(8'h25, 8'h06);
    // dropping the differential enable clears a latched request
    ev(8'h0f, 24'hff_efff, 1'b1);
    u_host.wr(8'h0b, 8'h07);
    repeat (3) @(negedge clk_sys);
    chk({23'h00_0000, irq_out}, 24'h00_0000);
    $display("t_events done");
  endtask
  task automatic t_zero;
    u_host.wr(8'h0b, 8'h20);
    cv(24'h10_0000);
    chk(output_pressure, 24'h00_0000);
    rdchk(8'h17, 8'h10);
    rdchk(8'h0b, 8'h00);
    cv(24'h10_0123);
    chk(output_pressure, 24'h00_0123);
    rdchk(8'h28, 8'h23);
    rdchk(8'h29, 8'h01);
    rdchk(8'h2a, 8'h00);
    u_host.wr(8'h0b, 8'h10);
    rdchk(8'h17, 8'h00);
    cv(24'h10_0123);
    chk(output_pressure, 24'h10_0123);
    $display("t_zero done");
  endtask
  // offset 0x0100 for the output, captured reference for the compare
  task automatic t_aref;
    u_host.wr(8'h18, 8'h00);
    u_host.wr(8'h19, 8'h01);
    rdchk(8'h18, 8'h00);
    rdchk(8'h19, 8'h01);
    u_host.arm(16'h0001, 8'h89);
    cv(24'h20_0000);
    chk(output_pressure, 24'h1f_ff00);
    chk({23'h00_0000, irq_out}, 24'h00_0000);
    rdchk(8'h0b, 8'h09);
    ev(8'h09, 24'h20_0101, 1'b1);
    chk(output_pressure, 24'h20_0001);
    ev(8'h09, 24'h20_0050, 1'b0);
    ev(8'h49, 24'h20_0050, 1'b1);
    chk(output_pressure, 24'h20_0050);
    $display("t_aref done");
  endtask
  ////////////////////////////////////////////////////////////////
  // hang guard, far above the under 200 cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'b0;
    conv_done = 1'b0;
    conv_pressure = 24'h00_0000;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_events();
    t_zero();
    t_aref();
    report_and_stop();
  end
endmodule

// ===== verilog/pti_cfg.svh
`ifndef PTI_CFG_SVH
`define PTI_CFG_SVH

// register byte addresses
`define PTI_ADDR_INT_CFG     8'h0b
`define PTI_ADDR_THS_LOW     8'h0c
`define PTI_ADDR_THS_HIGH    8'h0d
`define PTI_ADDR_REF_XL      8'h15
`define PTI_ADDR_REF_L       8'h16
`define PTI_ADDR_REF_H       8'h17
`define PTI_ADDR_OFS_L       8'h18
`define PTI_ADDR_OFS_H       8'h19
`define PTI_ADDR_INT_SRC     8'h25
`define PTI_ADDR_OUT_XL      8'h28
`define PTI_ADDR_OUT_L       8'h29
`define PTI_ADDR_OUT_H       8'h2a

// interrupt configuration field positions
`define PTI_CFG_HIGH_EN      0
`define PTI_CFG_LOW_EN       1
`define PTI_CFG_LATCH        2
`define PTI_CFG_DIFFERENTIAL_IRQ_ENABLE      3
`define PTI_CFG_AZ_RESET     4
`define PTI_CFG_AZ_CAPTURE   5
`define PTI_CFG_AR_RESET     6
`define PTI_CFG_AR_CAPTURE   7

// interrupt source field positions
`define PTI_SRC_HIGH         0
`define PTI_SRC_LOW          1
`define PTI_SRC_ACTIVE       2

// reset values
`define PTI_RST_BYTE         8'h00
`define PTI_RST_WORD16       16'h0000
`define PTI_RST_PRESS        24'h00_0000

// threshold lsb (1/16 hPa) to pressure lsb scaling, as a left shift
`define PTI_THS_SHIFT        8

`endif

// ===== verilog/pti_pkg.sv
package pti_pkg;

  typedef logic [23:0] pti_press_t;

  // what the output pressure registers report
  typedef enum logic [1:0] {
    PTI_OUT_RAW    = 2'b00,
    PTI_OUT_ZERO   = 2'b01,
    PTI_OUT_OFFSET = 2'b10
  } pti_out_mode_t;

endpackage

// ===== verilog/pti_threshold_irq.sv
// Notes on behaviour
// [R1] high enable set: event when compare value exceeds threshold; enable resets to zero
// [R2] low enable set: event when compare value falls below negative threshold
// [R3] host sets differential enable and loads both threshold bytes for events
// [R4] host enables high, low or both whenever differential enable is set
// [R5] in either capture mode compare value is measured minus stored reference
// [R6] auto-zero captures reference; output and compare become measured minus reference
// [R7] auto-zero bit self-clears after first conversion; zeroed behaviour continues
// [R8] auto-zero reset returns output to normal and clears reference registers
// [R9] auto-reference captures reference; compare becomes measured minus reference
// [R10] auto-reference mode output is measured minus the 16-bit pressure offset
// [R11] auto-reference bit self-clears after first conversion following its setting
// [R12] auto-reference reset returns to normal mode
// [R13] threshold is 16-bit unsigned; low byte at 0Ch, high byte at 0Dh
// [R14] threshold magnitude is value/16 hPa, symmetric positive and negative limit
// [R15] high threshold register holds only threshold bits 15 to 8
// [R16] low enable resets to zero, low interrupts disabled until set
// [R17] latch select: 1 holds request until source read, 0 follows comparison; code also drops a latched request when differential enable is cleared
// [R18] comparison evaluated once per completed conversion, updating high and low events
`timescale 1ns/10ps
`include "pti_cfg.svh"

module pti_threshold_irq #(
  parameter int THS_SHIFT = `PTI_THS_SHIFT
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              conv_done,
  input  wire pti_pkg::pti_press_t conv_pressure,
  output pti_pkg::pti_press_t    output_pressure,
  output logic                   irq_out
);
  import pti_pkg::*;

  // scaled threshold must stay below the sign bit of the compare width
  if (THS_SHIFT < 0 || THS_SHIFT > 9) begin : g_bad_shift
    $error("pti_threshold_irq: THS_SHIFT out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic          high_event_enable_reg;
  logic          low_event_enable_reg;
  logic          latch_select_reg;
  logic          differential_irq_enable_reg;
  logic          auto_zero_capture_reg;
  logic          auto_reference_capture_reg;
  logic [7:0]    pressure_threshold_low_reg;
  logic [7:0]    pressure_threshold_high_reg;
  logic [15:0]   pressure_offset_reg;
  pti_press_t    reference_pressure_reg;
  pti_press_t    output_pressure_reg;
  pti_out_mode_t out_mode_reg;
  logic          src_high_reg;
  logic          src_low_reg;
  logic          irq_reg;
  logic [7:0]    rdata_reg;

  logic          cfg_wr;
  logic          src_rd;
  logic          az_reset_wr;
  logic          ar_reset_wr;
  logic [15:0]   pressure_threshold;
  logic signed [25:0] cmp_value;
  logic signed [25:0] ths_pos;
  logic signed [25:0] ths_neg;
  logic          hit_high;
  logic          hit_low;
  pti_press_t    out_next;

  assign cfg_wr      = reg_wr && (reg_addr == `PTI_ADDR_INT_CFG);
  assign src_rd      = reg_rd && (reg_addr == `PTI_ADDR_INT_SRC);
  assign az_reset_wr = cfg_wr && reg_wdata[`PTI_CFG_AZ_RESET];
  assign ar_reset_wr = cfg_wr && reg_wdata[`PTI_CFG_AR_RESET];

  ////////////////////////////////////////////////////////////////////////////
  // interrupt configuration bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      high_event_enable_reg       <= 1'b0; // [R1]
      low_event_enable_reg        <= 1'b0; // [R16]
      latch_select_reg            <= 1'b0;
      differential_irq_enable_reg <= 1'b0;
    end else if (cfg_wr) begin
      high_event_enable_reg       <= reg_wdata[`PTI_CFG_HIGH_EN];
      low_event_enable_reg        <= reg_wdata[`PTI_CFG_LOW_EN];
      latch_select_reg            <= reg_wdata[`PTI_CFG_LATCH]; // [R17]
      differential_irq_enable_reg <= reg_wdata[`PTI_CFG_DIFFERENTIAL_IRQ_ENABLE];
    end
  end

  // capture requests: a fresh write wins over the self-clear of the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      auto_zero_capture_reg      <= 1'b0;
      auto_reference_capture_reg <= 1'b0;
    end else begin
      if (cfg_wr && reg_wdata[`PTI_CFG_AZ_CAPTURE]) begin
        auto_zero_capture_reg <= 1'b1;
      end else if (conv_done || az_reset_wr) begin
        auto_zero_capture_reg <= 1'b0; // [R7]
      end
      if (cfg_wr && reg_wdata[`PTI_CFG_AR_CAPTURE]) begin
        auto_reference_capture_reg <= 1'b1;
      end else if (conv_done || ar_reset_wr) begin
        auto_reference_capture_reg <= 1'b0; // [R11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold and offset bytes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pressure_threshold_low_reg  <= `PTI_RST_BYTE;
      pressure_threshold_high_reg <= `PTI_RST_BYTE;
      pressure_offset_reg         <= `PTI_RST_WORD16;
    end else if (reg_wr) begin
      case (reg_addr)
        `PTI_ADDR_THS_LOW:  pressure_threshold_low_reg  <= reg_wdata; // [R13]
        `PTI_ADDR_THS_HIGH: pressure_threshold_high_reg <= reg_wdata; // [R15]
        `PTI_ADDR_OFS_L:    pressure_offset_reg[7:0]    <= reg_wdata;
        `PTI_ADDR_OFS_H:    pressure_offset_reg[15:8]   <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // high byte only means something next to the low byte
  assign pressure_threshold = {pressure_threshold_high_reg, pressure_threshold_low_reg}; // [R13] [R15]

  ////////////////////////////////////////////////////////////////////////////
  // reference capture and output mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reference_pressure_reg <= `PTI_RST_PRESS;
    end else if (conv_done && (auto_zero_capture_reg || auto_reference_capture_reg)) begin
      reference_pressure_reg <= conv_pressure; // [R6] [R9]
    end else if (az_reset_wr) begin
      reference_pressure_reg <= `PTI_RST_PRESS; // [R8]
    end
  end

  // auto-zero takes the output over if both captures are pending together
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_mode_reg <= PTI_OUT_RAW;
    end else if (conv_done && auto_zero_capture_reg) begin
      out_mode_reg <= PTI_OUT_ZERO; // [R6]
    end else if (conv_done && auto_reference_capture_reg) begin
      out_mode_reg <= PTI_OUT_OFFSET; // [R10]
    end else if (az_reset_wr && out_mode_reg == PTI_OUT_ZERO) begin
      out_mode_reg <= PTI_OUT_RAW; // [R8]
    end else if (ar_reset_wr && out_mode_reg == PTI_OUT_OFFSET) begin
      out_mode_reg <= PTI_OUT_RAW; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare value and output value of the current conversion
  always_comb begin
    cmp_value = 26'(signed'(conv_pressure));
    out_next  = conv_pressure;
    // a capture in this very conversion already counts as the reference
    if (auto_zero_capture_reg) begin
      cmp_value = 26'sh000_0000;
      out_next  = `PTI_RST_PRESS;
    end else begin
      case (out_mode_reg)
        PTI_OUT_ZERO: begin
          cmp_value = 26'(signed'(conv_pressure)) - 26'(signed'(reference_pressure_reg)); // [R5]
          out_next  = conv_pressure - reference_pressure_reg; // [R6]
        end
        PTI_OUT_OFFSET: begin
          cmp_value = 26'(signed'(conv_pressure)) - 26'(signed'(reference_pressure_reg)); // [R5] [R9]
          out_next  = conv_pressure - 24'(signed'(pressure_offset_reg)); // [R10]
        end
        default: begin
        end
      endcase
      if (auto_reference_capture_reg) begin
        cmp_value = 26'sh000_0000;
        out_next  = conv_pressure - 24'(signed'(pressure_offset_reg)); // [R10]
      end
    end
  end

  // symmetric limits; threshold lsb is 1/16 hPa
  assign ths_pos  = signed'(26'(pressure_threshold) << THS_SHIFT); // [R14]
  assign ths_neg  = -ths_pos; // [R14]
  assign hit_high = differential_irq_enable_reg && high_event_enable_reg && (cmp_value > ths_pos); // [R1]
  assign hit_low  = differential_irq_enable_reg && low_event_enable_reg && (cmp_value < ths_neg); // [R2]

  ////////////////////////////////////////////////////////////////////////////
  // output pressure follows each conversion
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      output_pressure_reg <= `PTI_RST_PRESS;
    end else if (conv_done) begin
      output_pressure_reg <= out_next;
    end
  end

  // event flags: latched until source read or differential enable cleared, or renewed every conversion
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_high_reg <= 1'b0;
      src_low_reg  <= 1'b0;
    end else if (conv_done) begin
      if (latch_select_reg) begin
        // set beats a source read landing in the same cycle
        src_high_reg <= hit_high || (src_high_reg && !src_rd); // [R17] [R18]
        src_low_reg  <= hit_low || (src_low_reg && !src_rd); // [R17] [R18]
      end else begin
        src_high_reg <= hit_high; // [R18]
        src_low_reg  <= hit_low; // [R18]
      end
    end else if (src_rd && latch_select_reg) begin
      src_high_reg <= 1'b0; // [R17]
      src_low_reg  <= 1'b0;
    end else if (!differential_irq_enable_reg) begin
      src_high_reg <= 1'b0;
      src_low_reg  <= 1'b0;
    end
  end

  // pin follows the flags one cycle late so it comes straight from a flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= src_high_reg || src_low_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, one cycle latency, unmapped reads zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `PTI_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `PTI_ADDR_INT_CFG: begin
          rdata_reg <= {auto_reference_capture_reg, 1'b0, auto_zero_capture_reg, 1'b0,
                        differential_irq_enable_reg, latch_select_reg,
                        low_event_enable_reg, high_event_enable_reg};
        end
        `PTI_ADDR_THS_LOW:  rdata_reg <= pressure_threshold_low_reg;
        `PTI_ADDR_THS_HIGH: rdata_reg <= pressure_threshold_high_reg;
        `PTI_ADDR_REF_XL:   rdata_reg <= reference_pressure_reg[7:0];
        `PTI_ADDR_REF_L:    rdata_reg <= reference_pressure_reg[15:8];
        `PTI_ADDR_REF_H:    rdata_reg <= reference_pressure_reg[23:16];
        `PTI_ADDR_OFS_L:    rdata_reg <= pressure_offset_reg[7:0];
        `PTI_ADDR_OFS_H:    rdata_reg <= pressure_offset_reg[15:8];
        `PTI_ADDR_INT_SRC:  rdata_reg <= {5'b0_0000, src_high_reg || src_low_reg, src_low_reg, src_high_reg};
        `PTI_ADDR_OUT_XL:   rdata_reg <= output_pressure_reg[7:0];
        `PTI_ADDR_OUT_L:    rdata_reg <= output_pressure_reg[15:8];
        `PTI_ADDR_OUT_H:    rdata_reg <= output_pressure_reg[23:16];
        default:            rdata_reg <= `PTI_RST_BYTE;
      endcase
    end
  end

  assign reg_rdata       = rdata_reg;
  assign output_pressure = output_pressure_reg;
  assign irq_out         = irq_reg;

endmodule
